//--- rtl/color_result_pkg.sv
package color_result_pkg;
  // register read port
  localparam int ADDR_W = 8;
  localparam int WORD_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_C2_WORD0 = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_C2_WORD1 = 8'h05;
  localparam logic [ADDR_W-1:0] ADDR_C3_WORD0 = 8'h06;
  localparam logic [ADDR_W-1:0] ADDR_C3_WORD1 = 8'h07;
  localparam logic [WORD_W-1:0] UNMAPPED_READ = 16'h0000;

  // field widths
  localparam int RANGE_W = 4;
  localparam int SIG_W = 20;
  localparam int UPPER_W = 12;
  localparam int LOWER_W = 8;
  localparam int TALLY_W = 4;
  localparam int CHECK_W = 4;

  // field positions, first word
  localparam int RANGE_LSB = 12;
  localparam int UPPER_LSB = 0;
  // field positions, second word
  localparam int LOWER_LSB = 8;
  localparam int TALLY_LSB = 4;
  localparam int CHECK_LSB = 0;
  // upper part sits this far left in the significand
  localparam int UPPER_SHIFT = 8;

  // reset values and tally step
  localparam logic [RANGE_W-1:0] RANGE_RST = 4'h0;
  localparam logic [SIG_W-1:0] SIG_RST = 20'h00000;
  localparam logic [TALLY_W-1:0] TALLY_RST = 4'h0;
  localparam logic [CHECK_W-1:0] CHECK_RST = 4'h0;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [TALLY_W-1:0] TALLY_STEP = 4'h1;

  // channels handled here
  localparam int NUM_CH = 2;
endpackage

//--- rtl/check_code_calc.sv
`timescale 1ns/1ps
module check_code_calc
  import color_result_pkg::*;
(
  // measurement fields
  input wire logic [RANGE_W-1:0] i_range,
  input wire logic [SIG_W-1:0] i_sig,
  input wire logic [TALLY_W-1:0] i_operand,
  // check code
  output logic [CHECK_W-1:0] o_check
);
  logic odd_sig;
  logic quad_sig;

  always_comb begin
    odd_sig = 1'b0;
    quad_sig = 1'b0;
    for (int i = 1; i < SIG_W; i += 2) begin
      odd_sig = odd_sig ^ i_sig[i];
    end
    for (int i = 3; i < SIG_W; i += 4) begin
      quad_sig = quad_sig ^ i_sig[i];
    end
  end

  always_comb begin
    o_check[0] = ^{i_range, i_sig, i_operand};
    o_check[1] = i_operand[1] ^ i_operand[3] ^ odd_sig ^ i_range[1] ^ i_range[3];
    o_check[2] = i_operand[3] ^ quad_sig ^ i_range[3];
    o_check[3] = i_sig[3] ^ i_sig[11] ^ i_sig[19];
  end
endmodule

//--- rtl/chan_result_store.sv
`timescale 1ns/1ps
module chan_result_store
  import color_result_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // finished conversion
  input wire logic i_load,
  input wire logic [RANGE_W-1:0] i_range,
  input wire logic [SIG_W-1:0] i_sig,
  // packed result words
  output logic [WORD_W-1:0] o_word0,
  output logic [WORD_W-1:0] o_word1
);
  logic [TALLY_W-1:0] tally;
  logic [TALLY_W-1:0] next_tally;
  logic [CHECK_W-1:0] next_check;
  logic [UPPER_W-1:0] upper;
  logic [LOWER_W-1:0] lower;

  assign next_tally = tally + TALLY_STEP;
  assign upper = i_sig[SIG_W-1:UPPER_SHIFT];
  assign lower = i_sig[LOWER_W-1:0];

  // the check covers the tally that is stored alongside it
  check_code_calc u_check (
    .i_range(i_range),
    .i_sig(i_sig),
    .i_operand(next_tally),
    .o_check(next_check)
  );

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tally <= TALLY_RST;
    end else if (i_load) begin
      tally <= next_tally;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_word0 <= WORD_RST;
      o_word1 <= WORD_RST;
    end else if (i_load) begin
      o_word0 <= {i_range, upper};
      o_word1 <= {lower, next_tally, next_check};
    end
  end
endmodule

//--- rtl/color_channel_result_regs.sv
`timescale 1ns/1ps
// How it works
// - range code in first word bits 15-12
// - upper twelve significand bits in 11-0
// - lower eight significand bits in second word 15-8
// - significand is upper shifted eight plus lower
// - rolling tally bits 7-4, steps once per conversion, wraps from fh to 0
// - check bit 0 parity of everything
// - check bit 1 odd-bit parity
// - check bits 2,3 sparse parity terms
// - channel 2 at 4h/5h, 3 at 6h/7h, read-only
module color_channel_result_regs
  import color_result_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // channel 2 conversion results
  input wire logic i_conv_done_c2,
  input wire logic [RANGE_W-1:0] i_range_code_c2,
  input wire logic [SIG_W-1:0] i_light_value_significand_c2,
  // channel 3 conversion results
  input wire logic i_conv_done_c3,
  input wire logic [RANGE_W-1:0] i_range_code_c3,
  input wire logic [SIG_W-1:0] i_light_value_significand_c3,
  // register read port
  input wire logic i_rd_en,
  input wire logic [ADDR_W-1:0] i_rd_addr,
  output logic [WORD_W-1:0] o_rd_data,
  output logic o_rd_ack
);
  logic rst_meta_n;
  logic rst_n;
  logic [NUM_CH-1:0] conv_done;
  logic [RANGE_W-1:0] range_in [NUM_CH];
  logic [SIG_W-1:0] sig_in [NUM_CH];
  logic [WORD_W-1:0] word0 [NUM_CH];
  logic [WORD_W-1:0] word1 [NUM_CH];
  logic [WORD_W-1:0] shadow1 [NUM_CH];
  logic [NUM_CH-1:0] shadow_valid;
  logic [NUM_CH-1:0] hit_word0;
  logic [NUM_CH-1:0] hit_word1;
  logic [WORD_W-1:0] next_rd_data;

  // release reset through two flops
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  assign conv_done = {i_conv_done_c3, i_conv_done_c2};
  assign range_in[0] = i_range_code_c2;
  assign range_in[1] = i_range_code_c3;
  assign sig_in[0] = i_light_value_significand_c2;
  assign sig_in[1] = i_light_value_significand_c3;

  assign hit_word0[0] = (i_rd_addr == ADDR_C2_WORD0);
  assign hit_word1[0] = (i_rd_addr == ADDR_C2_WORD1);
  assign hit_word0[1] = (i_rd_addr == ADDR_C3_WORD0);
  assign hit_word1[1] = (i_rd_addr == ADDR_C3_WORD1);

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    chan_result_store u_store (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(rst_n),
      .i_load(conv_done[ch]),
      .i_range(range_in[ch]),
      .i_sig(sig_in[ch]),
      .o_word0(word0[ch]),
      .o_word1(word1[ch])
    );

    // pair-read snapshot
    // a new conversion may land between the two word reads, so the
    // second word is frozen when the first is read
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        shadow1[ch] <= WORD_RST;
        shadow_valid[ch] <= 1'b0;
      end else if (i_rd_en && hit_word0[ch]) begin
        shadow1[ch] <= word1[ch];
        shadow_valid[ch] <= 1'b1;
      end else if (i_rd_en) begin
        shadow_valid[ch] <= 1'b0;
      end
    end
  end

  always_comb begin
    next_rd_data = UNMAPPED_READ;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (hit_word0[ch]) begin
        next_rd_data = word0[ch];
      end else if (hit_word1[ch]) begin
        next_rd_data = shadow_valid[ch] ? shadow1[ch] : word1[ch];
      end
    end
  end

  // one-cycle read answer; writes do not exist on this port
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rd_data <= WORD_RST;
      o_rd_ack <= 1'b0;
    end else begin
      o_rd_ack <= i_rd_en;
      if (i_rd_en) begin
        o_rd_data <= next_rd_data;
      end
    end
  end
endmodule

//--- verification/color_result_monitor.sv
`timescale 1ns/1ps
module color_result_monitor
  import color_result_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // watched read port
  input wire logic i_rd_en,
  input wire logic [ADDR_W-1:0] i_rd_addr,
  input wire logic [WORD_W-1:0] o_rd_data,
  input wire logic o_rd_ack
);
  // last two read addresses and the word0 seen, to judge a 4h-5h pair
  logic [ADDR_W-1:0] la, lp;
  logic [WORD_W-1:0] w0;
  wire pr = o_rd_ack && la == 8'h05 && lp == 8'h04;
  always_ff @(posedge i_sys_clk) begin
    if (i_rd_en) la <= i_rd_addr;
    if (i_rd_en) lp <= la;
    if (o_rd_ack) w0 <= o_rd_data;
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  ack_after_a: assert property (i_rd_en |=> o_rd_ack) else $error("no ack");
  ack_cause_a: assert property (o_rd_ack |-> $past(i_rd_en)) else $error("stray ack");
  ack_pulse_a: assert property (!i_rd_en |=> !o_rd_ack) else $error("long ack");
  unmapped_zero_a: assert property (i_rd_en && i_rd_addr[7:2] != 6'h01 |=>
    o_rd_data == 16'h0000) else $error("unmapped data");
  data_hold_a: assert property (!i_rd_en |=> $stable(o_rd_data)) else $error("data moved");
  parity_all_a: assert property (pr |-> o_rd_data[0] == ^{w0, o_rd_data[15:4]})
    else $error("check bit 0");
  parity_mid_a: assert property (pr |-> o_rd_data[2] ==
    ^{o_rd_data[15], o_rd_data[11], o_rd_data[7], w0 & 16'h8888}) else $error("check bit 2");
  parity_top_a: assert property (pr |-> o_rd_data[3] ==
    ^{o_rd_data[11], w0[11], w0[3]}) else $error("check bit 3");
  cover property (pr);
  cover property (i_rd_en && i_rd_addr > 8'h07);
  cover property (o_rd_ack && o_rd_data != 16'h0000);
endmodule
bind color_channel_result_regs color_result_monitor i_mon (.*);

//--- verification/color_host_model.sv
`timescale 1ns/1ps
module color_host_model
  import color_result_pkg::*;
(
  // clock
  input wire logic i_sys_clk,
  // read answer
  input wire logic i_rd_ack,
  input wire logic [WORD_W-1:0] i_rd_data,
  // read request
  output logic o_rd_en = 1'b0,
  output logic [ADDR_W-1:0] o_rd_addr = 8'h00
);
  // one request edge; a released address is inverted so a late sample shows
  task automatic rd(logic [ADDR_W-1:0] a, output logic [WORD_W-1:0] d);
    @(negedge i_sys_clk);
    o_rd_en = 1'b1;
    o_rd_addr = a;
    @(negedge i_sys_clk);
    o_rd_en = 1'b0;
    o_rd_addr = ~a;
    d = i_rd_ack ? i_rd_data : 16'hxxxx;
  endtask
endmodule

//--- verification/color_channel_result_regs_tb.sv
`timescale 1ns/1ps
module color_channel_result_regs_tb;
  import color_result_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_rd_en, o_rd_ack;
  logic [1:0] done = 2'h0;
  logic [3:0] rng [2] = '{4'h0, 4'h0};
  logic [19:0] sig [2] = '{20'h0, 20'h0};
  logic [3:0] tal [2] = '{4'h0, 4'h0};
  logic [7:0] i_rd_addr;
  logic [15:0] o_rd_data, got, w1;
  int error_cnt = 0;
  int n_tests = 0;
  int seed = 32'hbf34;
  always #2 i_sys_clk = ~i_sys_clk;
  color_channel_result_regs i_dut (.i_sys_clk, .i_resetn, .i_conv_done_c2(done[0]),
    .i_range_code_c2(rng[0]), .i_light_value_significand_c2(sig[0]), .i_conv_done_c3(done[1]),
    .i_range_code_c3(rng[1]), .i_light_value_significand_c3(sig[1]), .i_rd_en, .i_rd_addr,
    .o_rd_data, .o_rd_ack);
  color_host_model i_host (.i_sys_clk, .i_rd_ack(o_rd_ack), .i_rd_data(o_rd_data),
    .o_rd_en(i_rd_en), .o_rd_addr(i_rd_addr));
  function automatic logic [15:0] w1f(logic [3:0] r, logic [19:0] s, logic [3:0] t);
    return {s[7:0], t, ^(s & 20'h80808), ^{t[3], s & 20'h88888, r[3]},
      ^{t[1], t[3], s & 20'haaaaa, r[1], r[3]}, ^{r, s, t}};
  endfunction
  task chk(logic [15:0] s, e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %0t %h %h", $time, s, e);
    end
  endtask
  task give_verdict;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task conv(int c, bit h);
    @(negedge i_sys_clk);
    done[c] = 1'b1;
    rng[c] = h ? 4'hf : 4'($random(seed));
    sig[c] = h ? 20'hfffff : 20'($random(seed));
    tal[c]++;
    @(negedge i_sys_clk);
    done[c] = 1'b0;
  endtask
  initial begin
    #20000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (10) @(negedge i_sys_clk);
    i_resetn = 1'b1;
    repeat (3) @(negedge i_sys_clk);
    for (int a = 0; a < 9; a++) begin
      i_host.rd(a[7:0], got);
      chk(got, WORD_RST);
    end
    for (int i = 0; i < 40; i++) begin
      conv(i % 2, i < 2);
      i_host.rd(ADDR_C2_WORD0 + 8'(2 * (i % 2)), got);
      chk(got, {rng[i % 2], sig[i % 2][19:8]});
      w1 = w1f(rng[i % 2], sig[i % 2], tal[i % 2]);
      if (i % 3 == 0) conv(i % 2, 1'b0);
      i_host.rd(ADDR_C2_WORD1 + 8'(2 * (i % 2)), got);
      chk(got, w1);
    end
    @(negedge i_sys_clk);
    i_resetn = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    i_resetn = 1'b1;
    repeat (3) @(negedge i_sys_clk);
    for (int a = 4; a < 8; a++) begin
      i_host.rd(a[7:0], got);
      chk(got, WORD_RST);
    end
    tal[0] = 4'h0;
    conv(0, 1'b0);
    i_host.rd(ADDR_C2_WORD1, got);
    chk(got, w1f(rng[0], sig[0], tal[0]));
    give_verdict();
  end
endmodule
